//--- spt_core.sv
/*
 * spt_core: rear port mux, output kill, fault pin, trigger select, list
 * sequencer, output timer, key lock and shortcut recall for a supply.
 * Assumes a classic Wishbone master, keys decoded to one-cycle codes and a
 * serial parser that strobes bus_trg_i on a trigger command.
 */
`timescale 1ns/1ns
module spt_core #(
    parameter int unsigned SEC_CYC_P = spt_pkg::SEC_CYC,
    parameter int unsigned MS_CYC_P = spt_pkg::MS_CYC,
    parameter int unsigned EXT_CYC_P = spt_pkg::EXT_TRIG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [spt_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic output_kill_input_pin_i,
    output logic fault_signal_pin_o,
    input wire logic ques_i,
    input wire logic oper_i,
    input wire logic esb_i,
    input wire logic rqs_i,
    input wire logic bus_trg_i,
    input wire logic key_valid_i,
    input wire logic [4:0] key_code_i,
    output logic key_accept_o,
    output logic output_on_o,
    output logic recall_o,
    output logic [3:0] recall_slot_o,
    output logic store_err_o,
    output logic list_step_stb_o,
    output logic [7:0] list_step_o,
    output logic list_busy_o,
    output logic [1:0] baud_sel_o,
    output logic [4:0] inst_addr_o,
    output logic [1:0] mem_layout_o
);
    import spt_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
            if (sel[i])
                old[i*8 +: 8] = nw[i*8 +: 8];
        return old;
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
        input logic [15:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    logic ack_reg;
    logic [31:0] dat_reg, rd_mux;
    logic [31:0] ctrl_reg, ctrl_wr;
    logic [15:0] timer_set_reg, timer_cnt_reg, len_reg, step_ms_reg, pw_reg, ms_cnt_reg;
    logic [8:0] slots_reg;
    logic [DIV_W-1:0] sec_div_reg, ms_div_reg;
    logic out_reg, locked_reg, fault_reg, key_acc_reg, recall_reg, err_reg, stb_reg;
    logic [3:0] slot_reg;
    logic [7:0] step_reg;
    spt_list_t ls_reg, ls_next;
    logic kill_lvl, kill_fall, ext_qual;

    spt_pin_sync #(
        .QUAL_CYC(EXT_CYC_P)
    ) u_kill_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(output_kill_input_pin_i),
        .level_o(kill_lvl),
        .fall_o(kill_fall),
        .qual_o(ext_qual)
    );

    // bus decode: one wait state, write lands on the ack edge
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_fire = req & wb_we_i & ack_reg;
    wire wr_ctrl = wr_fire && wb_adr_i == REG_CTRL;
    wire wr_timer = wr_fire && wb_adr_i == REG_TIMER;
    wire wr_cmd = wr_fire && wb_adr_i == REG_CMD;
    wire wr_len = wr_fire && wb_adr_i == REG_LIST_LEN;
    wire wr_step = wr_fire && wb_adr_i == REG_STEP_MS;
    wire wr_pw = wr_fire && wb_adr_i == REG_PASSWORD;
    wire wr_unlock = wr_fire && wb_adr_i == REG_UNLOCK;
    wire wr_slots = wr_fire && wb_adr_i == REG_SLOTS;
    wire [31:0] cmd_wr = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [31:0] pw_wr = merge({16'h0000, pw_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] timer_wr = merge({16'h0000, timer_set_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] len_wr = merge({16'h0000, len_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] step_wr = merge({16'h0000, step_ms_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] slots_wr = merge({23'h00_0000, slots_reg}, wb_dat_i, wb_sel_i);

    assign ctrl_wr = merge(ctrl_reg, wb_dat_i, wb_sel_i) & CTRL_MASK;
    // illegal encodings refuse the whole control write
    wire ctrl_ok = ctrl_wr[C_ADDR +: 5] <= MAX_ADDR && ctrl_wr[C_PORT +: 2] != 2'h3
        && ctrl_wr[C_KILL +: 2] != 2'h3 && ctrl_wr[C_TSRC +: 2] != 2'h3
        && ctrl_wr[C_FSRC +: 3] <= FS_RQS;

    wire spt_port_t port_mode = spt_port_t'(ctrl_reg[C_PORT +: 2]);
    wire spt_kill_t kill_mode = spt_kill_t'(ctrl_reg[C_KILL +: 2]);
    wire spt_fsrc_t fsrc = spt_fsrc_t'(ctrl_reg[C_FSRC +: 3]);
    wire spt_tsrc_t tsrc = spt_tsrc_t'(ctrl_reg[C_TSRC +: 2]);
    wire tmr_en = ctrl_reg[C_TMR_EN];
    wire step_mode = ctrl_reg[C_STEP_MODE];
    wire list_en = ctrl_reg[C_LIST_EN];

    // front-panel keys
    wire key_ok = key_valid_i & (~locked_reg | key_code_i == KEY_ONOFF);
    wire key_num = key_ok && key_code_i >= 5'h01 && key_code_i <= 5'h09;
    wire [3:0] num_idx = key_code_i[3:0] - 4'h1;
    wire do_recall = key_num & ctrl_reg[C_SHORTCUT] & slots_reg[num_idx];
    wire do_err = key_num & ctrl_reg[C_SHORTCUT] & ~slots_reg[num_idx];

    // trigger selection
    wire key_trig = key_ok && key_code_i == KEY_TRIG;
    wire ext_trig = ext_qual && port_mode == PORT_TRIG;
    wire bus_trig = bus_trg_i | (wr_cmd & cmd_wr[K_TRIG]);
    wire trig = (tsrc == TS_KEY && key_trig) || (tsrc == TS_EXT && ext_trig)
        || (tsrc == TS_BUS && bus_trig);

    // output state
    wire kill_port = port_mode == PORT_KILL;
    wire live = kill_port && kill_mode == KILL_LIVE;
    wire latch_off = kill_port && kill_mode == KILL_LATCH && kill_fall;
    wire sec_tick = sec_div_reg == DIV_W'(SEC_CYC_P - 1);
    wire tmr_expire = out_reg & tmr_en & timer_cnt_reg == 16'h0000;
    wire key_toggle = key_ok && key_code_i == KEY_ONOFF;
    wire out_next = live ? kill_lvl
        : (tmr_expire | latch_off | (wr_cmd & cmd_wr[K_OFF])) ? 1'b0
        : (wr_cmd & cmd_wr[K_ON]) ? 1'b1
        : key_toggle ? ~out_reg : out_reg;

    // fault pin
    wire fault_src_lvl = (fsrc == FS_QUES) ? ~ques_i
        : (fsrc == FS_OPER) ? oper_i
        : (fsrc == FS_ESB) ? esb_i
        : (fsrc == FS_RQS) ? rqs_i : 1'b1;
    wire fault_next = (port_mode == PORT_KILL) ? fault_src_lvl
        : (port_mode == PORT_DIO) ? ctrl_reg[C_DIG_OUT] : 1'b1;

    // list sequencer
    wire ms_tick = ms_div_reg == DIV_W'(MS_CYC_P - 1);
    // at or past the end, so shrinking the list mid-run cannot overrun it
    wire last_step = {8'h00, step_reg} >= len_reg - 16'h0001;
    wire step_done = ms_tick && ms_cnt_reg + 16'h0001 >= step_ms_reg;

    always_comb
    begin
        ls_next = ls_reg;
        unique case (ls_reg)
            LS_IDLE:
                if (trig)
                    ls_next = step_mode ? LS_WAIT : LS_RUN;
            LS_RUN:
                if (step_done && last_step)
                    ls_next = LS_IDLE;
            LS_WAIT:
                ls_next = LS_WAIT;
            default:
                ls_next = LS_IDLE;
        endcase
        if (!list_en)
            ls_next = LS_IDLE;
    end

    wire first_step = ls_reg == LS_IDLE && trig && list_en;
    wire adv_run = ls_reg == LS_RUN && step_done && !last_step;
    wire adv_wait = ls_reg == LS_WAIT && trig && list_en;
    wire [7:0] step_next = first_step ? 8'h00
        : adv_run ? step_reg + 8'h01
        : adv_wait ? (last_step ? 8'h00 : step_reg + 8'h01) : step_reg;

    assign rd_mux = (wb_adr_i == REG_CTRL) ? ctrl_reg
        : (wb_adr_i == REG_TIMER) ? {timer_cnt_reg, timer_set_reg}
        : (wb_adr_i == REG_STATUS) ? {16'h0000, step_reg, ls_reg, locked_reg, err_reg,
            fault_reg, kill_lvl, tmr_en & out_reg, out_reg}
        : (wb_adr_i == REG_LIST_LEN) ? {16'h0000, len_reg}
        : (wb_adr_i == REG_STEP_MS) ? {16'h0000, step_ms_reg}
        : (wb_adr_i == REG_PASSWORD) ? {31'h0000_0000, locked_reg}
        : (wb_adr_i == REG_SLOTS) ? {23'h00_0000, slots_reg} : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg)
                dat_reg <= rd_mux;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= CTRL_RST;
            timer_set_reg <= TIMER_RST;
            len_reg <= LEN_RST;
            step_ms_reg <= STEP_MIN_MS;
            pw_reg <= 16'h0000;
            locked_reg <= 1'b0;
            slots_reg <= 9'h000;
        end
        else if (ce_i)
        begin
            if (wr_ctrl && ctrl_ok)
                ctrl_reg <= ctrl_wr;
            if (wr_timer)
                timer_set_reg <= timer_wr[15:0];
            if (wr_len)
                len_reg <= clamp(len_wr[15:0], 16'h0001, MAX_STEPS);
            if (wr_step)
                step_ms_reg <= clamp(step_wr[15:0], STEP_MIN_MS, 16'hFFFF);
            if (wr_slots)
                slots_reg <= slots_wr[8:0];
            // zero password means no lock
            if (wr_pw)
            begin
                pw_reg <= pw_wr[15:0];
                locked_reg <= pw_wr[15:0] != 16'h0000;
            end
            else if (wr_unlock && wb_dat_i[15:0] == pw_reg)
                locked_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_reg <= 1'b0;
            sec_div_reg <= '0;
            timer_cnt_reg <= TIMER_RST;
            fault_reg <= 1'b1;
        end
        else if (ce_i)
        begin
            out_reg <= out_next;
            fault_reg <= fault_next;
            if (!out_reg || !tmr_en)
            begin
                sec_div_reg <= '0;
                timer_cnt_reg <= timer_set_reg;
            end
            else
            begin
                sec_div_reg <= sec_tick ? '0 : sec_div_reg + 1'b1;
                if (sec_tick && timer_cnt_reg != 16'h0000)
                    timer_cnt_reg <= timer_cnt_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            key_acc_reg <= 1'b0;
            recall_reg <= 1'b0;
            slot_reg <= 4'h0;
            err_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            key_acc_reg <= key_ok;
            recall_reg <= do_recall;
            if (do_recall)
                slot_reg <= key_code_i[3:0];
            // a new error in the clearing cycle stays set
            err_reg <= do_err | (err_reg & ~(wr_cmd & cmd_wr[K_CLR_ERR]));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ls_reg <= LS_IDLE;
            step_reg <= 8'h00;
            stb_reg <= 1'b0;
            ms_div_reg <= '0;
            ms_cnt_reg <= 16'h0000;
        end
        else if (ce_i)
        begin
            ls_reg <= ls_next;
            step_reg <= step_next;
            stb_reg <= first_step | adv_run | adv_wait;
            // step time only counts in the timed run; step mode waits on triggers
            if (ls_reg != LS_RUN || step_done)
            begin
                ms_div_reg <= '0;
                ms_cnt_reg <= 16'h0000;
            end
            else
            begin
                ms_div_reg <= ms_tick ? '0 : ms_div_reg + 1'b1;
                if (ms_tick)
                    ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign output_on_o = out_reg;
    assign fault_signal_pin_o = fault_reg;
    assign key_accept_o = key_acc_reg;
    assign recall_o = recall_reg;
    assign recall_slot_o = slot_reg;
    assign store_err_o = err_reg;
    assign list_step_stb_o = stb_reg;
    assign list_step_o = step_reg;
    assign list_busy_o = ls_reg != LS_IDLE;
    assign baud_sel_o = ctrl_reg[C_BAUD +: 2];
    assign inst_addr_o = ctrl_reg[C_ADDR +: 5];
    assign mem_layout_o = ctrl_reg[C_LAYOUT +: 2];

    a_timer_kills_out: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tmr_expire && !live |=> !output_on_o)
        else $error("timer expiry left output on");
    a_live_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && live |=> output_on_o == $past(kill_lvl))
        else $error("live kill output not following input");
    a_latch_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && port_mode == PORT_KILL && kill_mode == KILL_LATCH && kill_fall |=> !output_on_o)
        else $error("latching kill edge ignored");
    a_fault_ques: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && port_mode == PORT_KILL && fsrc == FS_QUES |=> fault_signal_pin_o == !$past(ques_i))
        else $error("fault pin not inverse of ques bit");
    a_fault_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (port_mode == PORT_KILL && fsrc == FS_OFF || port_mode == PORT_TRIG)
        |=> fault_signal_pin_o)
        else $error("fault pin not high when unused");
    a_lock_keys: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && locked_reg && key_valid_i && key_code_i != KEY_ONOFF |=> !key_accept_o)
        else $error("key accepted while locked");
    a_trig_source: assert property (@(posedge clk_i) disable iff (rst_i)
        ls_reg == LS_IDLE && ce_i && list_en && tsrc != TS_BUS && !key_trig && !ext_trig
        |=> ls_reg == LS_IDLE)
        else $error("list started by unselected source");
    a_step_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        {8'h00, list_step_o} < MAX_STEPS && len_reg <= MAX_STEPS && step_ms_reg >= STEP_MIN_MS)
        else $error("list step bounds broken");
    a_addr_range: assert property (@(posedge clk_i) disable iff (rst_i)
        inst_addr_o <= MAX_ADDR)
        else $error("instrument address out of range");
endmodule

//--- spt_pkg.sv
/*
 * spt_pkg: constants, register map and mode encodings shared by the supply
 * port / trigger / list control block and its pin conditioner.
 * Assumes a single 100 MHz clock and a classic Wishbone register bus.
 */
// Notes on behaviour
// - timer on: count programmed seconds to zero, then output off unless in live kill; off by default
// - shortcut recall: keys 1-9 recall stored slot; empty slot flags storage error
// - link rate 4800/9600/19200/38400 baud, default 4800; host must match
// - instrument address 0..30, default 0, selects which unit a command targets
// - port mode routes rear pins to trigger, kill/fault, or digital I/O
// - kill/fault mode: input pin controls output, second pin shows fault
// - digital I/O mode: remote reads input pin and sets output pin
// - three trigger sources: key, external pin, bus; only selected one triggers
// - key source: each trigger key press gives one trigger
// - bus source: each trigger command gives one trigger
// - latching kill: high-to-low edge on kill input turns output off
// - live kill: output on while kill input high, off while low
// - kill off: kill input has no effect on output
// - QUES selected: fault pin low while bit is 1, high while 0
// - OPER, ESB or RQS selected: fault pin tracks that bit
// - fault source off: fault pin held high
// - password set: all keys but output on/off ignored until unlocked
// - list holds at most 200 steps, step time at least 1 ms
// - list memory split as 1x4K, 2x2K, 4x1K or 8x512 byte groups
// - continuous list: each trigger runs whole list once, then idle
// - step list: one step per trigger, step duration ignored
package spt_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned EXT_TRIG_MIN_MS = 5;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned SEC_CYC = CLK_HZ;
    localparam int unsigned EXT_TRIG_CYC = MS_CYC * EXT_TRIG_MIN_MS;
    localparam int unsigned QUAL_W = 20;
    localparam int unsigned DIV_W = 27;
    localparam logic [15:0] STEP_MIN_MS = 16'h0001;
    localparam logic [15:0] MAX_STEPS = 16'h00C8;
    localparam logic [4:0] MAX_ADDR = 5'h1E;
    localparam int unsigned ADR_W = 8;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TIMER = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_LIST_LEN = 8'h10;
    localparam logic [7:0] REG_STEP_MS = 8'h14;
    localparam logic [7:0] REG_PASSWORD = 8'h18;
    localparam logic [7:0] REG_UNLOCK = 8'h1C;
    localparam logic [7:0] REG_SLOTS = 8'h20;

    // control register fields
    localparam int unsigned C_PORT = 0;
    localparam int unsigned C_KILL = 2;
    localparam int unsigned C_FSRC = 4;
    localparam int unsigned C_TSRC = 7;
    localparam int unsigned C_BAUD = 9;
    localparam int unsigned C_ADDR = 11;
    localparam int unsigned C_TMR_EN = 16;
    localparam int unsigned C_SHORTCUT = 17;
    localparam int unsigned C_STEP_MODE = 18;
    localparam int unsigned C_LAYOUT = 19;
    localparam int unsigned C_DIG_OUT = 21;
    localparam int unsigned C_LIST_EN = 22;
    localparam logic [31:0] CTRL_MASK = 32'h007F_FFFF;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // command register pulses
    localparam int unsigned K_TRIG = 0;
    localparam int unsigned K_ON = 1;
    localparam int unsigned K_OFF = 2;
    localparam int unsigned K_CLR_ERR = 3;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [15:0] LEN_RST = 16'h0001;

    typedef enum logic [1:0] {PORT_TRIG = 2'h0, PORT_KILL = 2'h1, PORT_DIO = 2'h2} spt_port_t;
    typedef enum logic [1:0] {KILL_OFF = 2'h0, KILL_LATCH = 2'h1, KILL_LIVE = 2'h2} spt_kill_t;
    typedef enum logic [2:0] {FS_OFF = 3'h0, FS_QUES = 3'h1, FS_OPER = 3'h2, FS_ESB = 3'h3,
        FS_RQS = 3'h4} spt_fsrc_t;
    typedef enum logic [1:0] {TS_KEY = 2'h0, TS_EXT = 2'h1, TS_BUS = 2'h2} spt_tsrc_t;
    typedef enum logic [1:0] {LS_IDLE = 2'b00, LS_RUN = 2'b01, LS_WAIT = 2'b11} spt_list_t;
    // key codes: 1..9 number keys
    localparam logic [4:0] KEY_TRIG = 5'h10;
    localparam logic [4:0] KEY_ONOFF = 5'h11;
endpackage

//--- spt_pin_sync.sv
/*
 * spt_pin_sync: two-stage synchroniser for one rear TTL input, with level,
 * falling-edge pulse and a width-qualified high pulse.
 * Assumes the pin is asynchronous and the caller holds ce_i for the whole block.
 */
`timescale 1ns/1ns
module spt_pin_sync #(
    parameter int unsigned QUAL_CYC = spt_pkg::EXT_TRIG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic pin_i,
    output logic level_o,
    output logic fall_o,
    output logic qual_o
);
    import spt_pkg::*;
    logic sync1_reg, sync2_reg, prev_reg, qual_reg;
    logic [QUAL_W-1:0] cnt_reg, cnt_next;
    localparam logic [QUAL_W-1:0] QUAL_N = QUAL_W'(QUAL_CYC);

    // counter saturates so one long high gives exactly one event
    assign cnt_next = !sync2_reg ? '0 : (cnt_reg == QUAL_N) ? cnt_reg : cnt_reg + 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            cnt_reg <= '0;
            qual_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            cnt_reg <= cnt_next;
            qual_reg <= sync2_reg && cnt_reg == QUAL_N - 1'b1;
        end
    end

    assign level_o = sync2_reg;
    assign fall_o = prev_reg & ~sync2_reg;
    assign qual_o = qual_reg;

    a_sync_two_stage: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2)
        |-> level_o == $past(pin_i, 2))
        else $error("input level not delayed by two stages");
    a_qual_width: assert property (@(posedge clk_i) disable iff (rst_i)
        qual_o |-> cnt_reg == QUAL_N && $past(cnt_reg) == QUAL_N - 1'b1)
        else $error("trigger qualified before minimum width");
endmodule

//--- spt_ttl_src.sv
/* spt_ttl_src: rear TTL equipment on pin 1, as a level or a trigger pulse.
   Assumes requests come from the bench, synchronous to clk_i. */
`timescale 1ns/1ns
module spt_ttl_src #(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic lvl_i,
    input wire logic pulse_i,
    output logic pin_o
);
    int cnt = 0;
    // margin over the minimum width, the device must not miss it
    always @(posedge clk_i)
        if (pulse_i)
            cnt <= W + 4;
        else if (cnt != 0)
            cnt <= cnt - 1;
    assign pin_o = lvl_i | (cnt != 0);
endmodule

//--- spt_core_bench.sv
/* spt_core_bench: self-checking bench for spt_core with a TTL source model.
   Assumes short count parameters and one 100 MHz clock. */
`timescale 1ns/1ns
module spt_core_bench;
    import spt_pkg::*;
    localparam int unsigned EXT = 8;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, kv = 0, btrg = 0, lvl = 0, pls = 0, ce = 1;
    logic [7:0] adr = 8'h00, lstep;
    logic [31:0] dat = 32'h0, q, rdat;
    logic [3:0] st = 4'h0, sel = 4'h0, lane = 4'hF, rslot;
    logic [4:0] kc = 5'h00, iaddr;
    logic ack, pin, fpin, on, serr, sstb, busy, kacc, rec;
    logic [1:0] baud, lay;
    int error_cnt = 0, tests_run = 0, ncyc = 0, nstb = 0, nacc = 0, nrec = 0, seed = 39, i, b;
    initial forever #5 clk_i = ~clk_i;
    spt_core #(.SEC_CYC_P(20), .MS_CYC_P(5), .EXT_CYC_P(EXT)) spt_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .output_kill_input_pin_i(pin), .fault_signal_pin_o(fpin),
        .ques_i(st[0]), .oper_i(st[1]), .esb_i(st[2]), .rqs_i(st[3]), .bus_trg_i(btrg),
        .key_valid_i(kv), .key_code_i(kc), .key_accept_o(kacc), .output_on_o(on),
        .recall_o(rec), .recall_slot_o(rslot), .store_err_o(serr), .list_step_stb_o(sstb),
        .list_step_o(lstep), .list_busy_o(busy), .baud_sel_o(baud), .inst_addr_o(iaddr),
        .mem_layout_o(lay));
    spt_ttl_src #(.W(EXT)) spt_ttl_src_inst (.clk_i(clk_i), .lvl_i(lvl), .pulse_i(pls),
        .pin_o(pin));
    always @(posedge clk_i)
    begin
        ncyc <= ncyc + 1;
        nstb <= nstb + int'(sstb);
        nacc <= nacc + int'(kacc);
        nrec <= nrec + int'(rec);
        if (ncyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task stop_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // classic cycle; the watchdog bounds the wait for ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= lane;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        cyc <= 0;
        @(posedge clk_i);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task key(input logic [4:0] c);
        @(posedge clk_i);
        kv <= 1;
        kc <= c;
        @(posedge clk_i);
        kv <= 0;
    endtask
    function logic [31:0] cw(input int p, k, f, t, h);
        return (h << 16) | (t << 7) | (f << 4) | (k << 2) | p;
    endfunction
    function logic fexp(input int f, input logic [3:0] s);
        return (f == 0) ? 1'b1 : (f == 1) ? ~s[0] : s[f-1];
    endfunction
    initial
    begin
        wt(4);
        rst_i <= 0;
        wt(2);
        chk("on", on, 0);
        chk("fault_pin", fpin, 1);
        chk("baud", baud, 0);
        chk("addr", iaddr, 0);
        wb(1, REG_CTRL, (30 << 11) | (3 << 9) | (3 << 19));
        chk("layout", lay, 3);
        chk("addr", iaddr, 30);
        chk("baud", baud, 3);
        wb(1, REG_CTRL, 31 << 11);
        chk("addr_refused", iaddr, 30);
        wb(0, 8'h40, 0);
        chk("unmapped", q, 0);
        // each source fires once per round, only the selected one counts
        for (i = 0; i < 3; i++)
        begin
            wb(1, REG_CTRL, cw(0, 0, 0, i, 8'h44));
            b = nstb;
            key(KEY_TRIG);
            @(posedge clk_i) btrg <= 1;
            @(posedge clk_i) btrg <= 0;
            @(posedge clk_i) pls <= 1;
            @(posedge clk_i) pls <= 0;
            wt(30);
            chk("trig_cnt", nstb - b, 1);
        end
        wb(1, REG_CTRL, 0);
        wb(1, REG_LIST_LEN, 500);
        wb(0, REG_LIST_LEN, 0);
        chk("len_clamp", q, 200);
        // only the low byte lane may land
        lane <= 4'h1;
        wb(1, REG_LIST_LEN, 32'h0000_0103);
        lane <= 4'hF;
        wb(0, REG_LIST_LEN, 0);
        chk("len_lane", q, 3);
        wb(1, REG_STEP_MS, 1);
        wb(1, REG_CTRL, cw(0, 0, 0, 0, 8'h40));
        for (i = 0; i < 2; i++)
        begin
            b = nstb;
            key(KEY_TRIG);
            wt(2);
            chk("list_busy", busy, 1);
            wt(58);
            chk("list_run", nstb - b, 3);
            chk("list_idle", busy, 0);
            chk("last_step", lstep, 2);
        end
        for (i = 0; i < 10; i++)
        begin
            wb(1, REG_CTRL, cw(1, 0, i % 5, 0, 0));
            st <= $random(seed);
            wt(4);
            chk("fault_pin", fpin, fexp(i % 5, st));
        end
        wb(1, REG_CTRL, cw(2, 0, 0, 0, 0));
        wt(2);
        chk("dout_lo", fpin, 0);
        wb(0, REG_STATUS, 0);
        chk("din_lo", q[2], 0);
        wb(1, REG_CTRL, cw(2, 0, 0, 0, 8'h20));
        lvl <= 1;
        wt(4);
        chk("dout", fpin, 1);
        wb(0, REG_STATUS, 0);
        chk("din", q[2], 1);
        wb(1, REG_CTRL, cw(1, 2, 0, 0, 0));
        wt(5);
        chk("live", on, 1);
        ce <= 0;
        lvl <= 0;
        wt(5);
        chk("ce_hold", on, 1);
        ce <= 1;
        wt(5);
        chk("live", on, 0);
        lvl <= 1;
        wb(1, REG_CTRL, cw(1, 1, 0, 0, 0));
        wb(1, REG_CMD, 2);
        chk("latch_on", on, 1);
        lvl <= 0;
        wt(5);
        chk("latch", on, 0);
        wb(1, REG_CTRL, cw(1, 0, 0, 0, 0));
        wb(1, REG_CMD, 2);
        lvl <= 1;
        wt(5);
        lvl <= 0;
        wt(5);
        chk("kill_off", on, 1);
        wb(1, REG_CMD, 4);
        wb(1, REG_TIMER, 2);
        wb(1, REG_CTRL, cw(0, 0, 0, 0, 1));
        wb(1, REG_CMD, 2);
        wt(10);
        chk("tmr_run", on, 1);
        wt(50);
        chk("tmr_end", on, 0);
        wb(1, REG_CTRL, cw(0, 0, 0, 0, 2));
        key(5'h03);
        wt(2);
        chk("empty_slot", serr, 1);
        wb(1, REG_CMD, 8);
        wb(1, REG_PASSWORD, 5);
        b = nacc;
        key(5'h03);
        wt(2);
        chk("locked_key", serr, 0);
        chk("locked_acc", nacc - b, 0);
        key(KEY_ONOFF);
        wt(2);
        chk("locked_onoff", on, 1);
        wb(1, REG_UNLOCK, 5);
        wb(1, REG_SLOTS, 4);
        b = nrec;
        key(5'h03);
        wt(2);
        chk("recall_cnt", nrec - b, 1);
        chk("recall_slot", rslot, 3);
        rst_i <= 1;
        wt(2);
        rst_i <= 0;
        wt(2);
        chk("rst_on", on, 0);
        chk("rst_addr", iaddr, 0);
        stop_test();
    end
endmodule
